// *** csm_top.sv ***
// Charger and system supply mode controller: power control and charger control
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
module csm_top (
    input  wire logic                  mclk_in,              // 25 MHz clock
    input  wire logic                  rst_n_in,             // Sync reset, active low
    input  wire logic                  ce_in,                // Clock enable
    input  wire logic                  path_config_fuse,     // Fuse: power-path
    input  wire logic                  charge_autonomy_fuse, // Fuse: hardware charging
    input  wire csm_pkg::csm_sense_t   sense_in,             // Comparators, detection
    input  wire csm_pkg::csm_phase_t   phase_in,             // Charging phase
    input  wire csm_pkg::csm_setting_t fuse_def_in,          // Fuse default settings
    input  wire logic [3:0]            addr_in,              // Register address
    input  wire logic [15:0]           wdata_in,             // Write data
    input  wire logic                  wr_in,                // Write strobe
    input  wire logic                  rd_in,                // Read strobe
    output logic [15:0]                rdata_out,            // Read data
    output logic                       powered_out,          // Device powered on
    output logic                       fallback_out,         // Fallback flag
    output logic                       term_irq_out,         // Termination event pulse
    output csm_pkg::csm_drive_t        drive_out,            // Regulator/charger enables
    output csm_pkg::csm_setting_t      set_out               // Settings to analog loops
);
    typedef struct packed {
        csm_pkg::csm_sense_t   sense;
        logic                  pp;
        logic                  auto_chg;
        logic                  fuse_seen;
        csm_pkg::csm_pwr_t     pwr;
        logic                  powered;
        logic                  fallback;
        logic                  locked;
        logic                  hw_started;
        logic                  term_done;
        logic                  term_irq;
        csm_pkg::csm_drive_t   drive;
        csm_pkg::csm_setting_t set;
    } csm_st_t;

    csm_st_t                st_r;
    csm_st_t                st_nxt;
    logic [15:0]            reg_rdata;
    logic [3:0]             reg_ctrl;
    csm_pkg::csm_setting_t  reg_set;
    logic                   reg_clr;
    logic [15:0]            status_w;

    // Startup condition depends on which node carries the system
    function automatic logic start_ok(input logic pp, input csm_pkg::csm_sense_t s);
        start_ok = pp ? s.sys_above_high : s.bat_above_high;
    endfunction

    function automatic logic source_on(input csm_pkg::csm_sense_t s);
        source_on = s.usb_present | s.wall_adapter_input;
    endfunction

    assign status_w = {5'h00, st_r.term_done, st_r.drive.chg_en, st_r.drive.reg_en,
                       st_r.locked, st_r.pwr, st_r.auto_chg, st_r.pp, st_r.fallback};

    csm_regs u_regs (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .addr_in   (addr_in),
        .wdata_in  (wdata_in),
        .wr_in     (wr_in),
        .rd_in     (rd_in),
        .status_in (status_w),
        .rdata_out (reg_rdata),
        .ctrl_out  (reg_ctrl),
        .set_out   (reg_set),
        .clr_out   (reg_clr)
    );

    always_comb begin
        logic shut;
        logic want_reg;
        logic want_chg;
        logic sw_owned;
        shut     = 1'b0;
        want_reg = 1'b0;
        want_chg = 1'b0;
        sw_owned = 1'b0;
        st_nxt   = st_r;
        st_nxt.sense    = sense_in;
        st_nxt.term_irq = 1'b0;

        // Fuses are caught once after reset release
        if (!st_r.fuse_seen) begin
            st_nxt.pp        = path_config_fuse;
            st_nxt.auto_chg  = charge_autonomy_fuse;
            st_nxt.fuse_seen = 1'b1;
        end

        // Power control flow
        case (st_r.pwr)
            csm_pkg::PWR_OFF: begin
                if (st_r.fuse_seen && source_on(st_r.sense) && start_ok(st_r.pp, st_r.sense))
                    st_nxt.pwr = csm_pkg::PWR_ON;
            end
            csm_pkg::PWR_ON: begin
                if (st_r.pp ? st_r.sense.sys_below_low : st_r.sense.bat_below_low) begin
                    shut = 1'b1;
                    st_nxt.pwr = csm_pkg::PWR_FALLBACK;
                end
            end
            csm_pkg::PWR_FALLBACK: begin
                // Restart threshold differs by configuration
                if (st_r.pp ? st_r.sense.bat_above_batmin : st_r.sense.bat_above_high)
                    st_nxt.pwr = csm_pkg::PWR_ON;
            end
            default: begin
                st_nxt.pwr = csm_pkg::PWR_OFF;
            end
        endcase
        // Decoded here so the output comes straight from a flop
        st_nxt.powered = (st_nxt.pwr == csm_pkg::PWR_ON);

        // Flag: shutdown sets it; set wins over a clear in the same cycle
        if (shut) begin
            st_nxt.fallback = 1'b1;
            if (st_r.fallback)
                st_nxt.locked = 1'b1;
        end else if (reg_clr) begin
            st_nxt.fallback = 1'b0;
        end
        // Lockout ends only when the source goes away, breaking restart loops
        if (!shut && !source_on(st_r.sense))
            st_nxt.locked = 1'b0;

        // Charger control flow, independent of power state updates above
        sw_owned = (st_r.pwr == csm_pkg::PWR_ON) && !st_r.auto_chg;
        if (st_r.auto_chg) begin
            if (st_r.sense.charging_port || st_r.sense.wall_adapter_input
                || (!st_r.sense.bat_above_batmin && st_r.pwr != csm_pkg::PWR_ON))
                st_nxt.hw_started = 1'b1;
            else if (!source_on(st_r.sense))
                st_nxt.hw_started = 1'b0;
            // Standard port with good battery or powered: wait for host
            want_reg = st_r.hw_started | reg_ctrl[csm_pkg::CTRL_REG_EN_BIT];
            want_chg = st_r.hw_started | reg_ctrl[csm_pkg::CTRL_CHG_EN_BIT];
        end else if (sw_owned) begin
            want_reg = reg_ctrl[csm_pkg::CTRL_REG_EN_BIT];
            want_chg = reg_ctrl[csm_pkg::CTRL_CHG_EN_BIT];
        end else begin
            want_reg = 1'b1;
            want_chg = 1'b1;
        end
        want_reg = want_reg & source_on(st_r.sense) & st_r.pp;
        want_chg = want_chg & source_on(st_r.sense);
        if (st_r.locked || shut) begin
            want_reg = 1'b0;
            want_chg = 1'b0;
        end

        // Settings: registers in autonomous charging mode or once the host owns charging, fuse defaults otherwise
        st_nxt.set = (st_r.auto_chg || sw_owned) ? reg_set : fuse_def_in;

        // Termination: event once, then gate until the phase restarts
        if (st_r.sense.term_reached && want_chg && !st_r.term_done) begin
            st_nxt.term_irq  = 1'b1;
            st_nxt.term_done = 1'b1;
        end else if (!st_r.sense.term_reached && !reg_ctrl[csm_pkg::CTRL_TERM_MODE_BIT]) begin
            st_nxt.term_done = 1'b0;
        end
        if (!want_chg)
            st_nxt.term_done = 1'b0;

        st_nxt.drive.reg_en         = want_reg;
        st_nxt.drive.chg_en         = want_chg & ~st_r.term_done;
        st_nxt.drive.precond_src_en = want_chg & st_r.pp & (phase_in == csm_pkg::PH_PRECOND);
        st_nxt.drive.ext_switch_en  = want_chg & st_r.pp & (phase_in != csm_pkg::PH_PRECOND);
        // Tracking only in full charge and end of charge
        st_nxt.drive.rail_track     = st_r.pp & st_r.set.track_mode
                                      & (phase_in == csm_pkg::PH_FULL || phase_in == csm_pkg::PH_EOC);
        st_nxt.drive.loop_margin    = {2'b00, st_r.set.dropout_setting[1]};
        if (!st_r.pp)
            st_nxt.drive.ext_switch_en = 1'b0;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r     <= '0;
            st_r.pwr <= csm_pkg::PWR_OFF;
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out    = reg_rdata;
    assign powered_out  = st_r.powered;
    assign fallback_out = st_r.fallback;
    assign term_irq_out = st_r.term_irq;
    assign drive_out    = st_r.drive;
    assign set_out      = st_r.set;
endmodule

// *** csm_pkg.sv ***
// Package for the charger and supply mode controller: constants, types, carriers
package csm_pkg;

    // Register offsets (plain register port, word addresses)
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h1;
    localparam logic [3:0] ADDR_INLIM     = 4'h2;
    localparam logic [3:0] ADDR_CHG       = 4'h3;
    localparam logic [3:0] ADDR_RAIL      = 4'h4;
    localparam logic [3:0] ADDR_FLAGCLR   = 4'h5;

    // Control register field positions
    localparam int CTRL_REG_EN_BIT    = 0;
    localparam int CTRL_CHG_EN_BIT    = 1;
    localparam int CTRL_TRACK_BIT     = 2;
    localparam int CTRL_TERM_MODE_BIT = 3;

    // Field positions of the limit, charge and rail registers
    localparam int INLIM_CUR_LSB   = 0;
    localparam int INLIM_COL_LSB   = 4;
    localparam int CHG_CUR_LSB     = 0;
    localparam int CHG_VOLT_LSB    = 4;
    localparam int CHG_TERM_LSB    = 10;
    localparam int RAIL_DROP_LSB   = 0;
    localparam int RAIL_PC_LSB     = 2;

    // Reset values
    localparam logic [3:0] RST_INPUT_CURRENT   = 4'h0;
    localparam logic [2:0] RST_COLLAPSE        = 3'h0;
    localparam logic [3:0] RST_CHARGE_CURRENT  = 4'h0;
    localparam logic [5:0] RST_CHARGE_VOLTAGE  = 6'h00;
    localparam logic [2:0] RST_TERM_CURRENT    = 3'h0;
    localparam logic [1:0] RST_DROPOUT         = 2'h0;
    localparam logic [5:0] RST_PRECOND_LEVEL   = 6'h00;

    // Power control states, one-hot
    typedef enum logic [3:0] {
        PWR_OFF      = 4'b0001,
        PWR_ON       = 4'b0010,
        PWR_FALLBACK = 4'b0100,
        PWR_LOCKED   = 4'b1000
    } csm_pwr_t;

    // Charging phases reported by the analog charger
    typedef enum logic [1:0] {
        PH_PRECOND  = 2'h0,
        PH_PRECHG   = 2'h1,
        PH_FULL     = 2'h2,
        PH_EOC      = 2'h3
    } csm_phase_t;

    // Comparator and detection inputs
    typedef struct packed {
        logic usb_present;
        logic wall_adapter_input;
        logic charging_port;
        logic sys_above_high;
        logic sys_below_low;
        logic bat_above_high;
        logic bat_below_low;
        logic bat_above_batmin;
        logic term_reached;
    } csm_sense_t;

    // Settings driven to the analog loops
    typedef struct packed {
        logic [3:0] input_current_limit;
        logic [2:0] input_collapse_level;
        logic [3:0] charge_current_setting;
        logic [5:0] charge_voltage_setting;
        logic [2:0] termination_current_setting;
        logic [1:0] dropout_setting;
        logic [5:0] preconditioning_rail_level;
        logic       track_mode;
    } csm_setting_t;

    // Regulator and charger enables
    typedef struct packed {
        logic reg_en;
        logic chg_en;
        logic precond_src_en;
        logic ext_switch_en;
        logic rail_track;
        logic [2:0] loop_margin;
    } csm_drive_t;

endpackage

// *** csm_regs.sv ***
// Register port of the charger controller: software settings and read mux
`timescale 1ns/1ns
module csm_regs (
    input  wire logic                  mclk_in,    // Clock
    input  wire logic                  rst_n_in,   // Sync reset
    input  wire logic                  ce_in,      // Clock enable
    input  wire logic [3:0]            addr_in,    // Register address
    input  wire logic [15:0]           wdata_in,   // Write data
    input  wire logic                  wr_in,      // Write strobe
    input  wire logic                  rd_in,      // Read strobe
    input  wire logic [15:0]           status_in,  // Live status word
    output logic [15:0]                rdata_out,  // Read data
    output logic [3:0]                 ctrl_out,   // Control bits
    output csm_pkg::csm_setting_t      set_out,    // Settings
    output logic                       clr_out     // Fallback clear pulse
);
    typedef struct packed {
        logic [15:0]           rdata;
        logic [3:0]            ctrl;
        csm_pkg::csm_setting_t set;
        logic                  clr;
    } csm_regs_st_t;

    csm_regs_st_t st_r;
    csm_regs_st_t st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.clr   = 1'b0;
        st_nxt.rdata = 16'h0000;
        if (wr_in) begin
            case (addr_in)
                csm_pkg::ADDR_CTRL: begin
                    st_nxt.ctrl = wdata_in[3:0];
                    st_nxt.set.track_mode = wdata_in[csm_pkg::CTRL_TRACK_BIT];
                end
                csm_pkg::ADDR_INLIM: begin
                    st_nxt.set.input_current_limit  = wdata_in[csm_pkg::INLIM_CUR_LSB +: 4];
                    st_nxt.set.input_collapse_level = wdata_in[csm_pkg::INLIM_COL_LSB +: 3];
                end
                csm_pkg::ADDR_CHG: begin
                    st_nxt.set.charge_current_setting      = wdata_in[csm_pkg::CHG_CUR_LSB +: 4];
                    st_nxt.set.charge_voltage_setting      = wdata_in[csm_pkg::CHG_VOLT_LSB +: 6];
                    st_nxt.set.termination_current_setting = wdata_in[csm_pkg::CHG_TERM_LSB +: 3];
                end
                csm_pkg::ADDR_RAIL: begin
                    st_nxt.set.dropout_setting            = wdata_in[csm_pkg::RAIL_DROP_LSB +: 2];
                    st_nxt.set.preconditioning_rail_level = wdata_in[csm_pkg::RAIL_PC_LSB +: 6];
                end
                csm_pkg::ADDR_FLAGCLR: begin
                    st_nxt.clr = wdata_in[0];
                end
                default: begin
                    st_nxt.clr = 1'b0;
                end
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                csm_pkg::ADDR_CTRL:   st_nxt.rdata = {12'h000, st_r.ctrl};
                csm_pkg::ADDR_STATUS: st_nxt.rdata = status_in;
                csm_pkg::ADDR_INLIM:  st_nxt.rdata = {9'h000, st_r.set.input_collapse_level,
                                                      st_r.set.input_current_limit};
                csm_pkg::ADDR_CHG:    st_nxt.rdata = {3'h0, st_r.set.termination_current_setting,
                                                      st_r.set.charge_voltage_setting,
                                                      st_r.set.charge_current_setting};
                csm_pkg::ADDR_RAIL:   st_nxt.rdata = {8'h00, st_r.set.preconditioning_rail_level,
                                                      st_r.set.dropout_setting};
                default:              st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r       <= '0;
            st_r.set   <= '{input_current_limit:         csm_pkg::RST_INPUT_CURRENT,
                            input_collapse_level:        csm_pkg::RST_COLLAPSE,
                            charge_current_setting:      csm_pkg::RST_CHARGE_CURRENT,
                            charge_voltage_setting:      csm_pkg::RST_CHARGE_VOLTAGE,
                            termination_current_setting: csm_pkg::RST_TERM_CURRENT,
                            dropout_setting:             csm_pkg::RST_DROPOUT,
                            preconditioning_rail_level:  csm_pkg::RST_PRECOND_LEVEL,
                            track_mode:                  1'b0};
        end else if (ce_in) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out = st_r.rdata;
    assign ctrl_out  = st_r.ctrl;
    assign set_out   = st_r.set;
    assign clr_out   = st_r.clr;
endmodule

// *** csm_checker.sv ***
// Port-level assertions for the charger mode controller
`timescale 1ns/1ns
module csm_checker (
    input wire logic                  mclk_in,          // Clock
    input wire logic                  rst_n_in,         // Sync reset
    input wire logic                  path_config_fuse, // Power-path fuse
    input wire csm_pkg::csm_sense_t   sense_in,         // Sense levels
    input wire logic [3:0]            addr_in,          // Address
    input wire logic [15:0]           wdata_in,         // Write data
    input wire logic                  wr_in,            // Write strobe
    input wire logic                  rd_in,            // Read strobe
    input wire logic [15:0]           rdata_out,        // Read data
    input wire logic                  powered_out,      // Powered on
    input wire logic                  fallback_out,     // Fallback flag
    input wire logic                  term_irq_out,     // Termination pulse
    input wire csm_pkg::csm_drive_t   drive_out,        // Enables
    input wire csm_pkg::csm_setting_t set_out           // Settings
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    rdata_idle_a: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_in && addr_in > 4'h5 |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    status_flag_a: assert property (rd_in && addr_in == csm_pkg::ADDR_STATUS
        |=> rdata_out[0] == $past(fallback_out))
        else $error("status flag bit differs from flag");
    fallback_set_a: assert property (powered_out && path_config_fuse && sense_in.sys_below_low
        |-> ##[1:3] (fallback_out && !powered_out))
        else $error("no shutdown on low rail");
    flag_clear_a: assert property (wr_in && addr_in == csm_pkg::ADDR_FLAGCLR && wdata_in[0]
        && !sense_in.sys_below_low && !sense_in.bat_below_low |-> ##[1:3] !fallback_out)
        else $error("flag not cleared by host");
    term_pulse_a: assert property (term_irq_out |=> !term_irq_out)
        else $error("termination event longer than one cycle");
    term_stop_a: assert property (term_irq_out |-> ##[0:2] !drive_out.chg_en)
        else $error("charging not stopped at termination");
    margin_a: assert property ((drive_out.chg_en && $stable(set_out.dropout_setting)) [*3]
        |-> drive_out.loop_margin == {2'b00, set_out.dropout_setting[1]})
        else $error("loop margin not half the dropout");
    no_pp_reg_a: assert property (!path_config_fuse |-> !drive_out.reg_en)
        else $error("regulator on without power path");
    startup_pp_a: assert property ((path_config_fuse && !fallback_out && sense_in.usb_present
        && sense_in.sys_above_high && !sense_in.sys_below_low) [*4] |-> powered_out)
        else $error("no startup with source and good rail");
    no_restart_a: assert property ((fallback_out && !powered_out && path_config_fuse
        && !sense_in.bat_above_batmin) [*3] |=> !powered_out)
        else $error("restart after fallback with low battery");
    np_start_a: assert property ((!path_config_fuse && !sense_in.bat_above_high && !powered_out) [*3]
        |=> !powered_out)
        else $error("startup with low battery");

    cover property ($rose(powered_out));
    cover property ($rose(fallback_out));
    cover property (term_irq_out);
endmodule

bind csm_top csm_checker csm_checker_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .path_config_fuse(path_config_fuse), .sense_in(sense_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .powered_out(powered_out), .fallback_out(fallback_out), .term_irq_out(term_irq_out),
    .drive_out(drive_out), .set_out(set_out)
);

// *** csm_partner.sv ***
// Charging source and battery model: comparator levels and charge phases
`timescale 1ns/1ns
module csm_partner (
    input  wire logic                mclk_in,    // Clock
    input  wire csm_pkg::csm_sense_t want_in,    // Levels the bench asks for
    input  wire logic                term_en_in, // Battery may reach full
    input  wire logic                chg_en_in,  // Charger running
    output csm_pkg::csm_sense_t      sense_out,  // Comparator levels
    output csm_pkg::csm_phase_t      phase_out   // Charging phase
);
    logic [4:0] age_r = 5'h00;

    // Phases advance only while charge flows; stopping restarts at precondition
    assign phase_out = csm_pkg::csm_phase_t'(age_r[4:3]);
    always_ff @(posedge mclk_in) begin
        age_r <= chg_en_in ? ((age_r == 5'h1f) ? age_r : age_r + 5'h01) : 5'h00;
        sense_out <= want_in;
        sense_out.term_reached <= term_en_in && (age_r == 5'h1f);
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the charger mode controller
`timescale 1ns/1ns
module tb;
    localparam logic [8:0] USB = 9'h100, PORT = 9'h040, SYSH = 9'h020, SYSL = 9'h010;
    localparam logic [8:0] BATH = 9'h008, BATL = 9'h004, BMIN = 9'h002;
    logic                  mclk_in = 1'b0;
    logic                  rst_n_in = 1'b0;
    logic                  pp_fuse = 1'b1;
    logic                  auto_fuse = 1'b1;
    csm_pkg::csm_sense_t   want = '0;
    csm_pkg::csm_sense_t   sense;
    csm_pkg::csm_phase_t   phase;
    csm_pkg::csm_setting_t fdef = {4'h9, 3'h3, 4'h4, 6'h11, 3'h2, 2'h1, 6'h0c, 1'b0};
    csm_pkg::csm_setting_t set;
    csm_pkg::csm_drive_t   drive;
    logic [3:0]            addr_in = 4'h0;
    logic [15:0]           wdata_in = 16'h0000;
    logic [15:0]           rdata;
    logic                  wr_in = 1'b0;
    logic                  rd_in = 1'b0;
    logic                  term_en = 1'b0;
    logic                  powered, fallback, irq;
    int                    failures = 0;
    int                    cmp_count = 0;
    int                    i;

    csm_top csm_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .path_config_fuse(pp_fuse),
        .charge_autonomy_fuse(auto_fuse), .sense_in(sense), .phase_in(phase), .fuse_def_in(fdef),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .powered_out(powered), .fallback_out(fallback), .term_irq_out(irq), .drive_out(drive), .set_out(set));
    csm_partner csm_partner_inst (.mclk_in(mclk_in), .want_in(want), .term_en_in(term_en),
        .chg_en_in(drive.chg_en), .sense_out(sense), .phase_out(phase));

    always #20 mclk_in = ~mclk_in;

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 chk(32'(rdata & m), 32'(exp));
    endtask

    // Comparators move one edge after the request, through the partner
    task automatic put(input logic [8:0] s);
        @(posedge mclk_in);
        want <= csm_pkg::csm_sense_t'(s);
        step(6);
    endtask

    // Fuses only change under reset, as they are read once after release
    task automatic boot(input logic pp, input logic au);
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        pp_fuse <= pp;
        auto_fuse <= au;
        want <= csm_pkg::csm_sense_t'(BMIN);
        term_en <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        step(3);
    endtask

    initial begin
        repeat (5000) @(posedge mclk_in);
        failures++;
        results();
    end

    initial begin
        boot(1'b1, 1'b1);
        rd(csm_pkg::ADDR_STATUS, 16'h000e, 16'hffff);
        rd(4'h7, 16'h0000, 16'hffff);
        wr(csm_pkg::ADDR_INLIM, 16'h0075);
        wr(csm_pkg::ADDR_CHG, 16'h16ba);
        wr(csm_pkg::ADDR_RAIL, 16'h0057);
        rd(csm_pkg::ADDR_INLIM, 16'h0075, 16'hffff);
        rd(csm_pkg::ADDR_CHG, 16'h16ba, 16'hffff);
        rd(csm_pkg::ADDR_RAIL, 16'h0057, 16'hffff);
        chk(32'({set.input_current_limit, set.input_collapse_level}), 32'h2f);
        chk(32'({set.charge_current_setting, set.charge_voltage_setting}), 32'h2ab);
        chk(32'({set.termination_current_setting, set.preconditioning_rail_level}), 32'h155);
        put(USB | SYSH | BMIN);
        chk(32'(powered), 32'h1);
        chk(32'({drive.reg_en, drive.chg_en}), 32'h0);
        wr(csm_pkg::ADDR_CTRL, 16'h0007);
        step(3);
        chk(32'({drive.reg_en, drive.chg_en, drive.precond_src_en, set.track_mode}), 32'hf);
        @(posedge mclk_in);
        term_en <= 1'b1;
        for (i = 0; i < 100 && irq !== 1'b1; i++) @(negedge mclk_in);
        chk(32'(irq), 32'h1);
        chk(32'({drive.ext_switch_en, drive.rail_track, drive.precond_src_en}), 32'h6);
        chk(32'(drive.loop_margin), 32'h1);
        @(posedge mclk_in);
        term_en <= 1'b0;
        step(1);
        chk(32'(drive.chg_en), 32'h0);
        wr(csm_pkg::ADDR_CTRL, 16'h0000);
        put(USB | SYSL);
        chk(32'({powered, fallback}), 32'h1);
        rd(csm_pkg::ADDR_STATUS, 16'h0001, 16'h0001);
        put(USB | SYSH);
        chk(32'({powered, fallback}), 32'h1);
        put(USB | SYSH | BMIN);
        chk(32'({powered, fallback}), 32'h3);
        put(USB | PORT | SYSL);
        chk(32'({powered, drive.reg_en, drive.chg_en}), 32'h0);
        rd(csm_pkg::ADDR_STATUS, 16'h0081, 16'h0081);
        put(BMIN);
        wr(csm_pkg::ADDR_FLAGCLR, 16'h0001);
        step(3);
        chk(32'(fallback), 32'h0);
        rd(csm_pkg::ADDR_FLAGCLR, 16'h0000, 16'hffff);
        put(USB | PORT | SYSH | BMIN);
        chk(32'({powered, drive.reg_en, drive.chg_en}), 32'h7);
        boot(1'b1, 1'b0);
        put(USB | BMIN);
        chk(32'({drive.reg_en, drive.chg_en}), 32'h3);
        chk(32'(set), 32'(fdef));
        put(USB | SYSH | BMIN);
        chk(32'({powered, drive.reg_en, drive.chg_en}), 32'h4);
        wr(csm_pkg::ADDR_CTRL, 16'h0002);
        step(3);
        chk(32'({drive.reg_en, drive.chg_en}), 32'h1);
        boot(1'b0, 1'b1);
        put(USB | SYSH | BMIN);
        chk(32'(powered), 32'h0);
        put(USB | SYSH | BATH | BMIN);
        chk(32'(powered), 32'h1);
        rd(csm_pkg::ADDR_STATUS, 16'h0014, 16'h00ff);
        put(USB | BATL | BMIN);
        chk(32'({powered, fallback}), 32'h1);
        results();
    end
endmodule
